// ### design/adc_pkg.sv
// Package: constants and types for the autodial adapter control block
package adc_pkg;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_DIAL       = 8'h05;
    localparam logic [7:0] CMD_LINE_CLEAR = 8'h01;
    localparam logic [7:0] CMD_ABORT      = 8'h02;

    // ****************************************
    // Dial codes (low nibble of a dial byte)
    // ****************************************
    localparam logic [3:0] DIGIT_MAX      = 4'h9;
    localparam logic [3:0] DIAL_END_CODE  = 4'hB;
    localparam logic [3:0] NUM_END_CODE   = 4'hC;
    localparam logic [3:0] DELAY_CODE     = 4'hF;

    // ****************************************
    // Register map (word offsets in bytes)
    // ****************************************
    localparam logic [3:0] OFS_CMD        = 4'h0;
    localparam logic [3:0] OFS_DIAL       = 4'h4;
    localparam logic [3:0] OFS_STATUS     = 4'h8;
    localparam logic [3:0] OFS_IRQ_STAT   = 4'hC;
    localparam logic [3:0] OFS_IRQ_MASK   = 4'h0;
    localparam logic       PAGE_MAIN      = 1'b0;
    localparam logic       PAGE_IRQ       = 1'b1;

    // Status and interrupt bit positions
    localparam int ST_CALL_REQ   = 0;
    localparam int ST_UNIT_FAULT = 1;
    localparam int ST_ABORT_RTRY = 2;
    localparam int ST_LINE_USE   = 3;
    localparam int ST_POWER_OK   = 4;
    localparam int ST_ANSWERED   = 5;
    localparam int ST_DIAL_BUSY  = 6;
    localparam int ST_TERM_RDY   = 7;
    localparam int IRQ_W         = 4;
    localparam int IRQ_FAULT     = 0;
    localparam int IRQ_ANSWER    = 1;
    localparam int IRQ_DIAL_DONE = 2;
    localparam int IRQ_CODE_TAKE = 3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ        = 40_000_000;
    localparam int DELAY_MS      = 1000;
    localparam int DELAY_CYC     = CLK_HZ / 1000 * DELAY_MS;
    localparam int STROBE_NS     = 100;
    localparam int STROBE_CYC    = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    typedef enum logic [1:0] {DL_IDLE, DL_STROBE, DL_PAUSE} adc_dial_type;

endpackage

// ### design/adc_sync.sv
// Two-flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
`default_nettype none
module adc_sync
#(
    parameter int W = 1
)
(
    input  wire logic         clock_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] async_i,
    output var  logic [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;

    // ****************************************
    // Per-bit double register
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            // First stage feeds only the second stage
            always_ff @(posedge clock_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    meta_ff[g] <= 1'b0;
                    sync_o[g]  <= 1'b0;
                end
                else
                begin
                    meta_ff[g] <= async_i[g];
                    sync_o[g]  <= meta_ff[g];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### design/adc_top.sv
// Autodial adapter control: call request, dial code output, Avalon-MM registers
//
// Notes on behaviour
// - Dial command raises originate request only if line free and power present.
// - Failed dial precondition leaves originate request unchanged for that command.
// - Dial with line in use, modem not answered: unit fault plus abort-retry.
// - Dial with line in use and modem answered: no unit fault.
// - Dial with calling unit power absent: unit fault plus abort-retry.
// - Dial bytes pass one at a time, no control table lookup.
// - Upper nibble of each dial byte is discarded; low nibble is the code.
// - Codes 0-9 digits, 1011 end dial, 1100 end number, 1111 delay.
// - Delay code is not dialed; it pauses about one second, may repeat.
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module adc_top
#(
    parameter int DELAY_CYCLES = adc_pkg::DELAY_CYC
)
(
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output var  logic [31:0] avs_readdata_o,
    output var  logic        avs_waitrequest_o,
    output var  logic        irq_o,
    // Calling unit and modem pins
    input  wire logic        line_in_use_i,
    input  wire logic        calling_unit_power_ok_i,
    input  wire logic        modem_answered_i,
    input  wire logic        present_next_digit_i,
    output var  logic        call_request_o,
    output var  logic        terminal_ready_o,
    output var  logic [3:0]  dial_code_o,
    output var  logic        digit_present_o
);
    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [3:0] pin_sync;
    logic       line_use_s;
    logic       power_ok_s;
    logic       answered_s;
    logic       pnd_s;

    adc_sync #(.W(4)) u_sync
    (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .async_i  ({present_next_digit_i, modem_answered_i,
                    calling_unit_power_ok_i, line_in_use_i}),
        .sync_o   (pin_sync)
    );

    assign line_use_s = pin_sync[0];
    assign power_ok_s = pin_sync[1];
    assign answered_s = pin_sync[2];
    assign pnd_s      = pin_sync[3];

    // ****************************************
    // Bus decode
    // ****************************************
    logic       pending_ff;
    logic       acc_wr;
    logic       acc_rd;
    logic [3:0] ofs;
    logic       page;
    logic       wr_cmd;
    logic       wr_dial;
    logic       wr_istat;
    logic       wr_imask;
    logic [7:0] cmd_byte;

    // One wait cycle: answer on the second edge of every access
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pending_ff <= 1'b0;
        else if (pending_ff)
            pending_ff <= 1'b0;
        else
            pending_ff <= avs_read_i | avs_write_i;
    end

    assign ofs      = {avs_address_i[1:0], 2'b00};
    assign page     = avs_address_i[2];
    assign acc_wr   = avs_write_i & pending_ff;
    assign acc_rd   = avs_read_i & pending_ff;
    assign cmd_byte = avs_writedata_i[7:0];
    assign wr_cmd   = acc_wr & avs_byteenable_i[0] & (page == adc_pkg::PAGE_MAIN)
                      & (ofs == adc_pkg::OFS_CMD);
    assign wr_dial  = acc_wr & avs_byteenable_i[0] & (page == adc_pkg::PAGE_MAIN)
                      & (ofs == adc_pkg::OFS_DIAL);
    assign wr_istat = acc_wr & avs_byteenable_i[0] & (page == adc_pkg::PAGE_MAIN)
                      & (ofs == adc_pkg::OFS_IRQ_STAT);
    assign wr_imask = acc_wr & avs_byteenable_i[0] & (page == adc_pkg::PAGE_IRQ)
                      & (ofs == adc_pkg::OFS_IRQ_MASK);

    logic is_dial_cmd;
    logic is_clear_cmd;
    logic is_abort_cmd;

    assign is_dial_cmd  = wr_cmd & (cmd_byte == adc_pkg::CMD_DIAL);
    assign is_clear_cmd = wr_cmd & (cmd_byte == adc_pkg::CMD_LINE_CLEAR);
    assign is_abort_cmd = wr_cmd & (cmd_byte == adc_pkg::CMD_ABORT);

    // ****************************************
    // Call request and fault status
    // ****************************************
    logic dial_ok;
    logic dial_fault;
    logic unit_fault_ff;
    logic abort_retry_ff;

    assign dial_ok    = !line_use_s & power_ok_s;
    // Line busy with modem answered is not a fault
    assign dial_fault = (line_use_s & !answered_s) | !power_ok_s;

    // Clear or abort outranks a dial written in the same cycle (cannot coincide)
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            call_request_o <= 1'b0;
        else if (is_clear_cmd | is_abort_cmd)
            call_request_o <= 1'b0;
        else if (is_dial_cmd & dial_ok)
            call_request_o <= 1'b1;
    end

    // Terminal ready rises with a good dial, drops with the call request
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            terminal_ready_o <= 1'b0;
        else if (is_clear_cmd | is_abort_cmd)
            terminal_ready_o <= 1'b0;
        else if (is_dial_cmd & dial_ok)
            terminal_ready_o <= 1'b1;
    end

    // Fault sense: re-evaluated on each dial, cleared by line clear
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            unit_fault_ff  <= 1'b0;
            abort_retry_ff <= 1'b0;
        end
        else if (is_dial_cmd)
        begin
            unit_fault_ff  <= dial_fault;
            abort_retry_ff <= dial_fault;
        end
        else if (is_clear_cmd)
        begin
            unit_fault_ff  <= 1'b0;
            abort_retry_ff <= 1'b0;
        end
    end

    // ****************************************
    // Dial byte path and delay pacing
    // ****************************************
    adc_pkg::adc_dial_type dl_state_ff;
    logic [31:0]           dl_cnt_ff;
    logic                  code_full_ff;
    logic [3:0]            code_ff;
    logic                  dial_done_ev;
    logic                  code_take_ev;
    logic                  pnd_d_ff;
    logic                  pnd_rise;

    // Only the low nibble is kept; no table lookup on dial bytes
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            code_full_ff <= 1'b0;
            code_ff      <= 4'h0;
        end
        else if (wr_dial & !code_full_ff & call_request_o)
        begin
            code_full_ff <= 1'b1;
            code_ff      <= avs_writedata_i[3:0];
        end
        else if (code_take_ev | is_clear_cmd | is_abort_cmd)
            code_full_ff <= 1'b0;
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pnd_d_ff <= 1'b0;
        else
            pnd_d_ff <= pnd_s;
    end

    assign pnd_rise = pnd_s & !pnd_d_ff;

    // Digit, end codes go out on the pins; delay only waits
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            dl_state_ff     <= adc_pkg::DL_IDLE;
            dl_cnt_ff       <= 32'h0000_0000;
            dial_code_o     <= 4'h0;
            digit_present_o <= 1'b0;
        end
        else if (is_clear_cmd | is_abort_cmd)
        begin
            dl_state_ff     <= adc_pkg::DL_IDLE;
            digit_present_o <= 1'b0;
        end
        else
        begin
            case (dl_state_ff)
                adc_pkg::DL_IDLE:
                begin
                    if (code_full_ff & (code_ff == adc_pkg::DELAY_CODE))
                    begin
                        dl_state_ff <= adc_pkg::DL_PAUSE;
                        dl_cnt_ff   <= 32'(DELAY_CYCLES - 1);
                    end
                    else if (code_full_ff)
                    begin
                        dial_code_o     <= code_ff;
                        digit_present_o <= 1'b1;
                        dl_state_ff     <= adc_pkg::DL_STROBE;
                    end
                end
                adc_pkg::DL_STROBE:
                begin
                    if (pnd_rise)
                    begin
                        digit_present_o <= 1'b0;
                        dl_state_ff     <= adc_pkg::DL_IDLE;
                    end
                end
                adc_pkg::DL_PAUSE:
                begin
                    if (dl_cnt_ff == 32'h0000_0000)
                        dl_state_ff <= adc_pkg::DL_IDLE;
                    else
                        dl_cnt_ff <= dl_cnt_ff - 32'h0000_0001;
                end
                default:
                    dl_state_ff <= adc_pkg::DL_IDLE;
            endcase
        end
    end

    // A code is consumed when its strobe is acknowledged or its pause ends
    assign code_take_ev = ((dl_state_ff == adc_pkg::DL_STROBE) & pnd_rise)
                          | ((dl_state_ff == adc_pkg::DL_PAUSE)
                             & (dl_cnt_ff == 32'h0000_0000));
    assign dial_done_ev = (dl_state_ff == adc_pkg::DL_STROBE) & pnd_rise
                          & (dial_code_o == adc_pkg::DIAL_END_CODE);

    // ****************************************
    // Interrupts
    // ****************************************
    logic [adc_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [adc_pkg::IRQ_W-1:0] irq_mask_ff;
    logic [adc_pkg::IRQ_W-1:0] irq_ev;
    logic                      ans_d_ff;

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ans_d_ff <= 1'b0;
        else
            ans_d_ff <= answered_s;
    end

    always_comb
    begin
        irq_ev                         = '0;
        irq_ev[adc_pkg::IRQ_FAULT]     = is_dial_cmd & dial_fault;
        irq_ev[adc_pkg::IRQ_ANSWER]    = answered_s & !ans_d_ff & call_request_o;
        irq_ev[adc_pkg::IRQ_DIAL_DONE] = dial_done_ev;
        irq_ev[adc_pkg::IRQ_CODE_TAKE] = code_take_ev;
    end

    // Set wins over write-one-to-clear in the same cycle
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_stat_ff <= '0;
        else if (wr_istat)
            irq_stat_ff <= (irq_stat_ff & ~avs_writedata_i[adc_pkg::IRQ_W-1:0]) | irq_ev;
        else
            irq_stat_ff <= irq_stat_ff | irq_ev;
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_mask_ff <= '0;
        else if (wr_imask)
            irq_mask_ff <= avs_writedata_i[adc_pkg::IRQ_W-1:0];
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_stat_ff & irq_mask_ff);
    end

    // ****************************************
    // Read mux and wait request
    // ****************************************
    logic [31:0] status_word;
    logic [31:0] rd_word;

    always_comb
    begin
        status_word                         = 32'h0000_0000;
        status_word[adc_pkg::ST_CALL_REQ]   = call_request_o;
        status_word[adc_pkg::ST_UNIT_FAULT] = unit_fault_ff;
        status_word[adc_pkg::ST_ABORT_RTRY] = abort_retry_ff;
        status_word[adc_pkg::ST_LINE_USE]   = line_use_s;
        status_word[adc_pkg::ST_POWER_OK]   = power_ok_s;
        status_word[adc_pkg::ST_ANSWERED]   = answered_s;
        status_word[adc_pkg::ST_DIAL_BUSY]  = code_full_ff;
        status_word[adc_pkg::ST_TERM_RDY]   = terminal_ready_o;
        rd_word                             = 32'h0000_0000;
        if (page == adc_pkg::PAGE_IRQ)
        begin
            if (ofs == adc_pkg::OFS_IRQ_MASK)
                rd_word = {28'h000_0000, irq_mask_ff};
        end
        else if (ofs == adc_pkg::OFS_STATUS)
            rd_word = status_word;
        else if (ofs == adc_pkg::OFS_IRQ_STAT)
            rd_word = {28'h000_0000, irq_stat_ff};
    end

    // Unmapped reads return zero, writes are dropped
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            avs_readdata_o <= 32'h0000_0000;
        else if (avs_read_i & !pending_ff)
            avs_readdata_o <= rd_word;
    end

    // Waitrequest low for one cycle once the access has been registered
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            avs_waitrequest_o <= 1'b1;
        else
            avs_waitrequest_o <= !((avs_read_i | avs_write_i) & !pending_ff);
    end

    logic unused_rd;
    assign unused_rd = acc_rd;
endmodule
`default_nettype wire

// ### design/unused.sv
// Spare design source: holds no logic

// ### sim/adc_caller_model.sv
// Partner model: calling unit that takes presented dial codes
`timescale 1ns/1ps
`default_nettype none
module adc_caller_model
(
    input  wire logic       clock_i,
    input  wire logic       arst_n_i,
    input  wire logic       slow_i,
    input  wire logic [3:0] dial_code_i,
    input  wire logic       digit_present_i,
    output var  logic       present_next_digit_o
);
    logic [3:0] codes [$];

    // Record each code, ask for the next after a short or long pause
    initial
    begin
        present_next_digit_o = 1'b0;
        forever
        begin
            @(posedge clock_i);
            if (arst_n_i && digit_present_i)
            begin
                codes.push_back(dial_code_i);
                repeat (slow_i ? 12 : 1) @(posedge clock_i);
                present_next_digit_o <= 1'b1;
                // Hold the request until the unit withdraws the code
                while (digit_present_i) @(posedge clock_i);
                present_next_digit_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/adc_top_sva.sv
// Checker: port-level assertions for the autodial adapter control block
`timescale 1ns/1ps
`default_nettype none
module adc_sva
(
    input wire logic        clock_i,
    input wire logic        arst_n_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic        avs_waitrequest_o,
    input wire logic        line_in_use_i,
    input wire logic        calling_unit_power_ok_i,
    input wire logic        present_next_digit_i,
    input wire logic        call_request_o,
    input wire logic        terminal_ready_o,
    input wire logic [3:0]  dial_code_o,
    input wire logic        digit_present_o
);
    // ****************************************
    // Helper and assertions
    // ****************************************
    // Host line clear or abort seen on the command word
    logic clr_cmd;
    assign clr_cmd = avs_write_i && (avs_address_i[2:0] == 3'h0)
        && (avs_writedata_i[7:0] inside {adc_pkg::CMD_LINE_CLEAR, adc_pkg::CMD_ABORT});

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_wait_answer_bound: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |-> ##[1:2] !avs_waitrequest_o)
        else $error("bus request not answered in time");
    a_ready_with_req: assert property (terminal_ready_o == call_request_o)
        else $error("terminal ready differs from call request");
    a_req_needs_ok: assert property ($rose(call_request_o)
        |-> $past(calling_unit_power_ok_i, 3) && !$past(line_in_use_i, 3))
        else $error("call request raised without line free and power");
    a_req_holds: assert property ($fell(call_request_o)
        |-> $past(clr_cmd, 1) || $past(clr_cmd, 2))
        else $error("call request dropped without clear or abort");
    a_code_legal: assert property ($rose(digit_present_o)
        |-> (dial_code_o <= adc_pkg::DIGIT_MAX) || (dial_code_o == adc_pkg::DIAL_END_CODE)
        || (dial_code_o == adc_pkg::NUM_END_CODE))
        else $error("unusable or delay code presented");
    a_code_stable: assert property (digit_present_o && $past(digit_present_o)
        |-> $stable(dial_code_o))
        else $error("dial code changed while presented");
    a_drop_on_ack: assert property ($fell(digit_present_o) |-> !call_request_o
        || $past(present_next_digit_i, 1) || $past(present_next_digit_i, 2)
        || $past(present_next_digit_i, 3) || $past(present_next_digit_i, 4))
        else $error("digit present dropped without acknowledge");
endmodule

bind adc_top adc_sva u_sva
(
    .clock_i(clock_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_waitrequest_o(avs_waitrequest_o), .line_in_use_i(line_in_use_i),
    .calling_unit_power_ok_i(calling_unit_power_ok_i),
    .present_next_digit_i(present_next_digit_i), .call_request_o(call_request_o),
    .terminal_ready_o(terminal_ready_o), .dial_code_o(dial_code_o),
    .digit_present_o(digit_present_o)
);
`default_nettype wire

// ### sim/autodial_adapter_control_bench.sv
// Testbench: scenarios for the autodial adapter control block
`timescale 1ns/1ps
`default_nettype none
module autodial_adapter_control_bench;
    logic        clock_i, arst_n_i, rd, wr, line, pwr, ans, pnd, slow;
    logic        wait_o, irq, creq, tready, dpres;
    logic [4:0]  adr;
    logic [3:0]  code;
    logic [31:0] wdat, rdat, q;
    int          fails, n_tests, cyc;

    // Clock at 40 MHz and a free cycle count for timing checks
    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) cyc <= cyc + 1;

    // Short pause count keeps the delay scenario quick
    adc_top #(.DELAY_CYCLES(20)) u_dut
    (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .irq_o(irq),
        .line_in_use_i(line), .calling_unit_power_ok_i(pwr), .modem_answered_i(ans),
        .present_next_digit_i(pnd), .call_request_o(creq), .terminal_ready_o(tready),
        .dial_code_o(code), .digit_present_o(dpres)
    );
    adc_caller_model u_caller
    (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .slow_i(slow), .dial_code_i(code),
        .digit_present_i(dpres), .present_next_digit_o(pnd)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon access; held until waitrequest is sampled low
    // No local limit: only the watchdog ends a wait for the answer
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= d;
        do
            @(posedge clock_i);
        while (wait_o !== 1'b0);
        chk("waitrequest", 32'h0, {31'h0, wait_o});
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic cmd(input logic [7:0] c);
        bus(1'b1, 5'h00, {24'h0, c});
    endtask

    // Check abort, fault and call request in status and at the pins
    task automatic st(input logic [2:0] e);
        bus(1'b0, 5'h02, 32'h0);
        chk("status", {29'h0, e}, {29'h0, q[2:0]});
        chk("call_request_o", {31'h0, e[0]}, {31'h0, creq});
        chk("terminal_ready_o", {31'h0, e[0]}, {31'h0, tready});
    endtask

    // Pins pass a two-stage synchroniser, so allow settling time
    task automatic pins(input logic l, input logic p, input logic a);
        line <= l;
        pwr <= p;
        ans <= a;
        repeat (4) @(posedge clock_i);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        do
        begin
            bus(1'b0, 5'h02, 32'h0);
            n++;
        end
        while (q[adc_pkg::ST_DIAL_BUSY] !== 1'b0 && n < 200);
        chk("code_pending", 32'h0, {31'h0, q[adc_pkg::ST_DIAL_BUSY]});
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        chk("call_request_o", 32'h0, {31'h0, creq});
        chk("irq_o", 32'h0, {31'h0, irq});
        bus(1'b0, 5'h04, 32'h0);
        chk("irq_mask_reset", 32'h0, q);
        bus(1'b1, 5'h05, 32'hFFFFFFFF);
        bus(1'b0, 5'h05, 32'h0);
        chk("unmapped", 32'h0, q);
    endtask

    task automatic t_irq;
        pins(1'b0, 1'b0, 1'b0);
        cmd(adc_pkg::CMD_DIAL);
        bus(1'b0, 5'h03, 32'h0);
        chk("irq_fault", 32'h1, {31'h0, q[adc_pkg::IRQ_FAULT]});
        chk("irq_o_masked", 32'h0, {31'h0, irq});
        bus(1'b1, 5'h04, 32'h1);
        bus(1'b0, 5'h04, 32'h0);
        chk("irq_mask", 32'h1, {28'h0, q[3:0]});
        chk("irq_o_set", 32'h1, {31'h0, irq});
        bus(1'b1, 5'h03, 32'hF);
        repeat (2) @(posedge clock_i);
        chk("irq_o_clear", 32'h0, {31'h0, irq});
        bus(1'b1, 5'h04, 32'h0);
        cmd(adc_pkg::CMD_LINE_CLEAR);
    endtask

    // Table of {line, power, answered, fault expected}
    task automatic t_fault;
        logic [3:0] tab [4] = '{4'b0001, 4'b1101, 4'b1110, 4'b1011};
        for (int i = 0; i < 4; i++)
        begin
            pins(tab[i][3], tab[i][2], tab[i][1]);
            cmd(adc_pkg::CMD_DIAL);
            st({tab[i][0], tab[i][0], 1'b0});
            cmd(adc_pkg::CMD_LINE_CLEAR);
            st(3'b000);
        end
    endtask

    task automatic t_dial;
        logic [7:0] b [6] = '{8'h31, 8'hA9, 8'h50, 8'hFF, 8'h6C, 8'h2B};
        logic [3:0] xc [5] = '{4'h1, 4'h9, 4'h0, 4'hC, 4'hB};
        int         t0;
        pins(1'b0, 1'b1, 1'b0);
        cmd(adc_pkg::CMD_DIAL);
        st(3'b001);
        for (int i = 0; i < 6; i++)
        begin
            slow <= i[0];
            wait_idle();
            t0 = cyc;
            bus(1'b1, 5'h01, {24'h0, b[i]});
            if (b[i][3:0] == adc_pkg::DELAY_CODE)
            begin
                wait_idle();
                chk("delay_pause", 32'h1, {31'h0, (cyc - t0 >= 20) && (cyc - t0 <= 45)});
            end
        end
        wait_idle();
        repeat (8) @(posedge clock_i);
        chk("codes_seen", 32'd5, 32'(u_caller.codes.size()));
        for (int i = 0; i < 5; i++)
            chk("dial_code", {28'h0, xc[i]}, {28'h0, u_caller.codes[i]});
        // Modem answers while the call request still stands
        pins(1'b0, 1'b1, 1'b1);
        bus(1'b0, 5'h03, 32'h0);
        chk("irq_dial_done", 32'h3, {30'h0, q[3:2]});
        chk("irq_answered", 32'h1, {31'h0, q[adc_pkg::IRQ_ANSWER]});
        // A failing dial during a call leaves the request standing
        pins(1'b0, 1'b0, 1'b0);
        cmd(adc_pkg::CMD_DIAL);
        st(3'b111);
        pins(1'b0, 1'b1, 1'b0);
        cmd(adc_pkg::CMD_LINE_CLEAR);
        st(3'b000);
        cmd(adc_pkg::CMD_DIAL);
        st(3'b001);
        cmd(adc_pkg::CMD_ABORT);
        st(3'b000);
    endtask

    task automatic conclude;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        #500000;
        fails++;
        conclude();
    end

    // Main sequence
    initial
    begin
        {arst_n_i, rd, wr, line, pwr, ans, slow} = '0;
        adr = 5'h00;
        wdat = 32'h0;
        fails = 0;
        n_tests = 0;
        cyc = 0;
        repeat (4) @(posedge clock_i);
        arst_n_i <= 1'b1;
        @(posedge clock_i);
        t_reset();
        t_irq();
        t_fault();
        t_dial();
        conclude();
    end
endmodule
`default_nettype wire
